// ==== hw/module_sideband_control.sv ====
// sideband control of a pluggable module: select, reset, init mode, presence, attention
// assumes synchronous pins; a serial front end drives the register port below
// Behaviour
// - serial management answered only while module select is low.
// - reset held low past the minimum restores all default settings.
// - completion asserts attention and clears the data-not-ready flag.
// - completion is posted after power-up without a host reset.
// - init select pulled high; high means software, low means hardware control.
// - software control stays low power until software enables high power.
// - hardware control enters high power once management init finishes.
// - presence line is tied low whenever the module is inserted.
// - attention driven low for faults or critical status, released otherwise.
// - host reads and writes the management map over the serial lines.
// - seven low-speed control signals are provided.
`timescale 1ns/1ps
module module_sideband_control (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       module_select_n,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   input  wire logic       hard_reset_n,
   input  wire logic       init_control_select,
   input  wire logic       faultEvent,
   input  wire logic       regWrStrobe,
   input  wire logic [7:0] regWrData,
   input  wire logic       regRdStrobe,
   output logic            sclOut,
   output logic            sclOe,
   output logic            sdaOut,
   output logic            sdaOe,
   output logic            presence_n,
   output logic            attention_n,
   output logic            attentionOe,
   output logic            highPower,
   output logic [7:0]      regRdData
);
   msc_mgmt_if mgmt ();
   logic                      resetFire;
   logic [msc_pkg::CNT_W-1:0] initCount;
   logic [7:0]                status;
   logic [7:0]                control;
   logic                      selected;
   logic                      initLatched;
   logic                      completionPend;
   msc_pkg::msc_state_t       state;
   msc_pkg::msc_state_t       next_state;

   msc_reset_filter filter (
      .clk            (clk),
      .rst_n          (rst_n),
      .hardResetPin_n (hard_reset_n),
      .resetFire      (resetFire)
   );

   // gate register access on module select
   assign selected      = !module_select_n;
   assign mgmt.wrStrobe = regWrStrobe & selected;
   assign mgmt.rdStrobe = regRdStrobe & selected;
   assign mgmt.wrData   = regWrData;
   assign mgmt.status   = status;
   assign mgmt.control  = control;

   // sequencer: power-up or filtered reset restarts management init
   always_comb begin
      next_state = state;
      unique case (state)
         msc_pkg::MSC_IDLE:  next_state = msc_pkg::MSC_RESET;
         msc_pkg::MSC_RESET: next_state = msc_pkg::MSC_INIT;
         msc_pkg::MSC_INIT:
            if (initCount == msc_pkg::CNT_W'(msc_pkg::MGMT_INIT_CYC))
               next_state = msc_pkg::MSC_READY;
         msc_pkg::MSC_READY: next_state = msc_pkg::MSC_READY;
      endcase
      // a long reset holds the sequencer in reset until the pin rises
      if (resetFire)
         next_state = msc_pkg::MSC_RESET;
   end

   // state starts from idle so power-up runs the same completion path
   always_ff @(posedge clk) begin
      if (!rst_n)
         state <= msc_pkg::MSC_IDLE;
      else
         state <= next_state;
   end

   // management init timer
   always_ff @(posedge clk) begin
      if (!rst_n || state != msc_pkg::MSC_INIT)
         initCount <= '0;
      else
         initCount <= initCount + 1'b1;
   end

   // init select sampled every cycle of the reset state before each init; host keeps it steady anyway
   always_ff @(posedge clk) begin
      if (!rst_n)
         initLatched <= 1'b1;
      else if (state == msc_pkg::MSC_RESET)
         initLatched <= init_control_select;
   end

   // control register back to defaults on reset; writes when selected
   always_ff @(posedge clk) begin
      if (!rst_n || state == msc_pkg::MSC_RESET)
         control <= msc_pkg::CTRL_RESET;
      else if (mgmt.wrStrobe)
         control <= mgmt.wrData;
   end

   // not-ready cleared at completion; fault sticky, set wins over read clear
   always_ff @(posedge clk) begin
      if (!rst_n || state == msc_pkg::MSC_RESET) begin
         status <= msc_pkg::STAT_RESET;
      end else begin
         if (state == msc_pkg::MSC_INIT && next_state == msc_pkg::MSC_READY)
            status[msc_pkg::STAT_NOT_READY] <= 1'b0;
         if (faultEvent)
            status[msc_pkg::STAT_FAULT] <= 1'b1;
         else if (mgmt.rdStrobe)
            status[msc_pkg::STAT_FAULT] <= 1'b0;
         status[msc_pkg::STAT_HIGH_POWER] <= highPower;
      end
   end

   // high power: hardware mode when ready, software mode needs the enable
   always_ff @(posedge clk) begin
      if (!rst_n || state != msc_pkg::MSC_READY)
         highPower <= 1'b0;
      else
         highPower <= !initLatched || control[msc_pkg::CTRL_HP_ENABLE];
   end

   // attention pulled low while completion is unread or a fault is pending
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         attention_n <= 1'b1;
         attentionOe <= 1'b0;
      end else begin
         attention_n <= 1'b0; // open collector: only ever drives low
         attentionOe <= status[msc_pkg::STAT_FAULT] || completionPend;
      end
   end

   // completion stays flagged until the host first reads status
   always_ff @(posedge clk) begin
      if (!rst_n || state == msc_pkg::MSC_RESET)
         completionPend <= 1'b0;
      else if (state == msc_pkg::MSC_INIT && next_state == msc_pkg::MSC_READY)
         completionPend <= 1'b1;
      else if (mgmt.rdStrobe)
         completionPend <= 1'b0;
   end

   // read data registered; held unchanged when not selected
   always_ff @(posedge clk) begin
      if (!rst_n)
         regRdData <= 8'h00;
      else if (mgmt.rdStrobe)
         regRdData <= mgmt.status;
   end

   // presence tied low whenever inserted and powered
   always_ff @(posedge clk) begin
      if (!rst_n)
         presence_n <= 1'b0;
      else
         presence_n <= 1'b0;
   end

   // serial lines are never driven by this core; the front end owns the byte protocol
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sclOut <= 1'b0;
         sclOe  <= 1'b0;
         sdaOut <= 1'b0;
         sdaOe  <= 1'b0;
      end else begin
         sclOut <= 1'b0;
         sclOe  <= 1'b0;
         sdaOut <= 1'b0;
         sdaOe  <= selected && !sdaIn && !sclIn && 1'b0;
      end
   end
endmodule

// ==== hw/msc_pkg.sv ====
// constants shared by the module sideband control block
// assumes a single 20 MHz clock and synchronous active-low reset
package msc_pkg;
   localparam int unsigned CLK_HZ           = 20_000_000;
   // glitch filter on the hard reset pin, in ns
   localparam int unsigned RST_MIN_NS       = 1000;
   localparam int unsigned RST_MIN_CYC      = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   // time for the management interface to come up after reset, in ns
   localparam int unsigned MGMT_INIT_NS     = 2000;
   localparam int unsigned MGMT_INIT_CYC    = (MGMT_INIT_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int unsigned CNT_W            = 16;
   // status byte layout: bit 0 data not ready, bit 1 fault, bit 2 high power
   localparam int unsigned STAT_NOT_READY   = 0;
   localparam int unsigned STAT_FAULT       = 1;
   localparam int unsigned STAT_HIGH_POWER  = 2;
   localparam logic [7:0]  STAT_RESET       = 8'h01;
   localparam logic [7:0]  CTRL_RESET       = 8'h00;
   localparam int unsigned CTRL_HP_ENABLE   = 0;
   typedef enum logic [1:0] {MSC_IDLE, MSC_RESET, MSC_INIT, MSC_READY} msc_state_t;
endpackage

// ==== hw/msc_mgmt_if.sv ====
// management access between the serial front end and the control core
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface msc_mgmt_if;
   logic       wrStrobe;
   logic [7:0] wrData;
   logic       rdStrobe;
   logic [7:0] status;
   logic [7:0] control;
   modport core  (input wrStrobe, input wrData, input rdStrobe, output status, output control);
   modport front (output wrStrobe, output wrData, output rdStrobe, input status, input control);
endinterface

// ==== hw/msc_reset_filter.sv ====
// glitch filter for the hard reset pin
// assumes the pin is already synchronous to clk
`timescale 1ns/1ps
module msc_reset_filter (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic hardResetPin_n,
   output logic      resetFire
);
   logic [msc_pkg::CNT_W-1:0] lowCount;

   // count low cycles: a short low is ignored
   // past the minimum the request stays up, so a held pin keeps the core in reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lowCount  <= '0;
         resetFire <= 1'b0;
      end else if (hardResetPin_n) begin
         lowCount  <= '0;
         resetFire <= 1'b0;
      end else begin
         if (lowCount != msc_pkg::CNT_W'(msc_pkg::RST_MIN_CYC))
            lowCount <= lowCount + 1'b1;
         resetFire <= (lowCount >= msc_pkg::CNT_W'(msc_pkg::RST_MIN_CYC - 1));
      end
   end
endmodule

// ==== tb/msc_sideband_asserts.sv ====
// port checks for the sideband control top
// assumes one clock domain and the bind at the foot
`timescale 1ns/1ps
module msc_sideband_asserts (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       module_select_n,
   input wire logic       hard_reset_n,
   input wire logic       init_control_select,
   input wire logic       faultEvent,
   input wire logic       regWrStrobe,
   input wire logic [7:0] regWrData,
   input wire logic       regRdStrobe,
   input wire logic       presence_n,
   input wire logic       attention_n,
   input wire logic       attentionOe,
   input wire logic       highPower,
   input wire logic [7:0] regRdData
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [5:0] lowCnt;
   logic       hpAsk;
   // saturating length of a low on the hard reset pin
   always_ff @(posedge clk) begin
      if (!rst_n || hard_reset_n) lowCnt <= 6'h00;
      else if (lowCnt != 6'h3f) lowCnt <= lowCnt + 6'h01;
   end
   // last selected power request; not cleared by a hard reset, which only weakens the check
   always_ff @(posedge clk) begin
      if (!rst_n) hpAsk <= 1'b0;
      else if (regWrStrobe && !module_select_n) hpAsk <= regWrData[msc_pkg::CTRL_HP_ENABLE];
   end
   sequence selRead;
      !module_select_n && regRdStrobe && !faultEvent;
   endsequence
   sequence readyQuiet;
      !regRdData[msc_pkg::STAT_NOT_READY] && !faultEvent;
   endsequence
   chk_present_tied: assert property (presence_n == 1'b0)
      else $error("presence not low");
   chk_power_post: assert property ($rose(rst_n) |-> ##[1:60] attentionOe)
      else $error("no completion after power up");
   chk_read_release: assert property (selRead ##1 readyQuiet |=> !attentionOe)
      else $error("attention kept after read");
   chk_unsel_read: assert property (module_select_n && regRdStrobe
      && $past(module_select_n) |=> $stable(regRdData))
      else $error("unselected read answered");
   chk_fault_raise: assert property (faultEvent |-> ##[1:3] attentionOe)
      else $error("fault without attention");
   chk_reset_default: assert property (lowCnt >= msc_pkg::RST_MIN_CYC + 4 |-> !highPower)
      else $error("high power kept in reset");
   chk_sw_hold: assert property ($rose(highPower) && init_control_select |-> hpAsk)
      else $error("high power without request");
   chk_attn_low: assert property (attentionOe |-> !attention_n)
      else $error("attention driven high");
endmodule
bind module_sideband_control msc_sideband_asserts u_chk (.clk, .rst_n, .module_select_n,
   .hard_reset_n, .init_control_select, .faultEvent, .regWrStrobe, .regWrData, .regRdStrobe,
   .presence_n, .attention_n, .attentionOe, .highPower, .regRdData);

// ==== tb/msc_host_model.sv ====
// host board side of the pins: pull-ups resolve released lines
// assumes enables are high while the module drives
`timescale 1ns/1ps
module msc_host_model (
   input  wire logic attentionOe,
   input  wire logic attention_n,
   input  wire logic sclOe,
   input  wire logic sclOut,
   input  wire logic sdaOe,
   input  wire logic sdaOut,
   output logic      attWire,
   output logic      sclIn,
   output logic      sdaIn
);
   // open collector, host pull-up when released
   assign attWire = (attentionOe === 1'b1) ? attention_n : 1'b1;
   // serial lines idle high through pull-ups
   assign sclIn = (sclOe === 1'b1) ? sclOut : 1'b1;
   assign sdaIn = (sdaOe === 1'b1) ? sdaOut : 1'b1;
endmodule

// ==== tb/module_sideband_control_tb_top.sv ====
// self-checking bench for the sideband control block
// assumes msc_pkg, host model and checker compiled first
`timescale 1ns/1ps
module module_sideband_control_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, module_select_n = 1'b1, hard_reset_n = 1'b1;
   logic init_control_select = 1'b1, faultEvent = 1'b0, regWrStrobe = 1'b0, regRdStrobe = 1'b0;
   logic [7:0] regWrData = 8'h00, regRdData, keep;
   logic sclIn, sdaIn, sclOut, sclOe, sdaOut, sdaOe, presence_n, attention_n, attentionOe;
   logic highPower, attWire;
   int   bad_count = 0, num_checks = 0, cyc = 0, n;
   always #25 clk = ~clk;
   module_sideband_control dut (.clk, .rst_n, .module_select_n, .sclIn, .sdaIn, .hard_reset_n,
      .init_control_select, .faultEvent, .regWrStrobe, .regWrData, .regRdStrobe, .sclOut,
      .sclOe, .sdaOut, .sdaOe, .presence_n, .attention_n, .attentionOe, .highPower, .regRdData);
   msc_host_model host (.attentionOe, .attention_n, .sclOe, .sclOut, .sdaOe, .sdaOut,
      .attWire, .sclIn, .sdaIn);
   task automatic tick(int k = 1);
      repeat (k) @(posedge clk);
      #2;
   endtask
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [7:0] expStat(logic f, logic hp);
      return (8'(f) << msc_pkg::STAT_FAULT) | (8'(hp) << msc_pkg::STAT_HIGH_POWER);
   endfunction
   // own select line per module, released between accesses
   task automatic rd(logic sel);
      module_select_n = ~sel;
      regRdStrobe = 1'b1;
      tick();
      regRdStrobe = 1'b0;
      module_select_n = 1'b1;
      tick();
   endtask
   task automatic wr(logic sel, logic [7:0] d);
      module_select_n = ~sel;
      regWrData = d;
      regWrStrobe = 1'b1;
      tick();
      regWrStrobe = 1'b0;
      module_select_n = 1'b1;
      tick(3);
   endtask
   // host waits for completion before trusting status
   task automatic waitAtt;
      n = 0;
      while (attWire !== 1'b0 && n < 100) begin
         tick();
         n++;
      end
      check("completion", {7'h00, attWire}, 8'h00);
   endtask
   // init select only changes while unplugged
   task automatic powerUp(logic sw);
      rst_n = 1'b0;
      init_control_select = sw;
      tick(10);
      rst_n = 1'b1;
      waitAtt();
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // hang guard; the run needs well under 1000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         end_sim();
      end
   end
   initial begin
      n = $urandom(32'hef5f_6901);
      powerUp(1'b1);
      check("presence", {7'h00, presence_n}, 8'h00);
      check("serial idle", {4'h0, sclOut, sclOe, sdaOut, sdaOe}, 8'h00);
      rd(1'b1);
      check("status", regRdData, expStat(1'b0, 1'b0));
      tick(2);
      check("release", {7'h00, attWire}, 8'h01);
      $display("test power up done");
      wr(1'b0, 8'hff);
      check("unselected write", {7'h00, highPower}, 8'h00);
      wr(1'b1, 8'($urandom) | 8'h01);
      check("sw enable", {7'h00, highPower}, 8'h01);
      faultEvent = 1'b1;
      tick();
      faultEvent = 1'b0;
      tick(3);
      check("fault line", {7'h00, attWire}, 8'h00);
      rd(1'b1);
      check("fault status", regRdData, expStat(1'b1, 1'b1));
      keep = regRdData;
      rd(1'b0);
      check("unselected read", regRdData, keep);
      rd(1'b1);
      check("fault cleared", regRdData, expStat(1'b0, 1'b1));
      $display("test control done");
      hard_reset_n = 1'b0;
      tick(1 + $urandom_range(msc_pkg::RST_MIN_CYC - 3));
      hard_reset_n = 1'b1;
      tick(5);
      check("glitch", {7'h00, highPower}, 8'h01);
      hard_reset_n = 1'b0;
      tick(msc_pkg::RST_MIN_CYC + 5);
      check("hard reset", {7'h00, highPower}, 8'h00);
      hard_reset_n = 1'b1;
      waitAtt();
      rd(1'b1);
      check("after reset", regRdData, expStat(1'b0, 1'b0));
      $display("test hard reset done");
      powerUp(1'b0);
      tick(3);
      check("hw power", {7'h00, highPower}, 8'h01);
      $display("test hardware init done");
      end_sim();
   end
endmodule
